// ---- logic/pcr_pkg.sv ----
`default_nettype none
package pcr_pkg;
	// Direct addresses of the general registers; page bytes also answer at 4002h to 4004h.
	localparam logic [15:0] ADDR_SOFT_RST = 16'h0000;
	localparam logic [15:0] ADDR_PAGE_LO = 16'h0002;
	localparam logic [15:0] ADDR_PAGE_MID = 16'h0003;
	localparam logic [15:0] ADDR_PAGE_HI = 16'h0004;
	localparam logic [3:0] ALIAS_AREA = 4'h4;
	localparam logic [15:0] ADDR_MASTER_SEL = 16'h0012;
	localparam logic [15:0] ADDR_PDN = 16'h0020;
	// Upper address nibbles of the paged and direct digital areas; the link area uses the top three bits.
	localparam logic [3:0] AREA_DDC = 4'h5;
	localparam logic [3:0] AREA_MAIN = 4'h6;
	localparam logic [2:0] AREA_LINK = 3'h3;
	// Area codes passed to each channel bank.
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_MAIN = 2'h1;
	localparam logic [1:0] SEL_DDC = 2'h2;
	localparam logic [1:0] SEL_LINK = 2'h3;
	// Offsets inside a channel's area.
	localparam logic [11:0] OFF_DIG_RST = 12'h000;
	localparam logic [11:0] OFF_DDC_EN = 12'h000;
	localparam logic [11:0] OFF_DECIM = 12'h001;
	localparam logic [11:0] OFF_NCO_LO = 12'h007;
	localparam logic [11:0] OFF_NCO_HI = 12'h008;
	localparam logic [11:0] OFF_GAIN = 12'h014;
	localparam logic [11:0] OFF_LINK_MODE = 12'h002;
	localparam logic [11:0] OFF_SCRAM = 12'h006;
	// Field positions.
	localparam int SRST_HI_BIT = 7;
	localparam int SRST_LO_BIT = 0;
	localparam int MASTER_SEL_BIT = 2;
	localparam int GPDN_BIT = 0;
	localparam int SCRAM_BIT = 7;
	localparam int ENABLE_BIT = 0;
	// Reset values.
	localparam logic [23:0] SEL_RST = 24'h000000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	// Selector codes of the digital pages.
	localparam logic [23:0] PAGE_VAL_MAIN_A = 24'h680000;
	localparam logic [23:0] PAGE_VAL_MAIN_B = 24'h680100;
	localparam logic [23:0] PAGE_VAL_FUNC_A = 24'h610000;
	localparam logic [23:0] PAGE_VAL_FUNC_B = 24'h610100;
	localparam logic [23:0] PAGE_VAL_LINK = 24'h690000;

	typedef enum logic [2:0] {PAGE_NONE, PAGE_MAIN_A, PAGE_MAIN_B, PAGE_FUNC_A,
		PAGE_FUNC_B, PAGE_LINK} pcr_page_e;

	// Maps a selector value to the page it names; unknown values select nothing.
	function automatic pcr_page_e pcr_decode(input logic [23:0] sel);
		pcr_page_e p;
		p = PAGE_NONE;
		case (sel)
			PAGE_VAL_MAIN_A: p = PAGE_MAIN_A;
			PAGE_VAL_MAIN_B: p = PAGE_MAIN_B;
			PAGE_VAL_FUNC_A: p = PAGE_FUNC_A;
			PAGE_VAL_FUNC_B: p = PAGE_FUNC_B;
			PAGE_VAL_LINK: p = PAGE_LINK;
			default: p = PAGE_NONE;
		endcase
		return p;
	endfunction
endpackage
`default_nettype wire

// ---- logic/pcr_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcr_chan
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic sw_rst,
	input wire logic wr,
	input wire logic [1:0] area,
	input wire logic [11:0] off,
	input wire logic [7:0] wdata,
	output logic [7:0] rd_word,
	output logic dig_rst,
	output logic ddc_en,
	output logic [7:0] decim,
	output logic [15:0] nco_word,
	output logic gain6_en,
	output logic scram_en,
	output logic fmt_mode
);
	logic dig_rst_ff, ddc_en_ff, gain_ff, scram_ff, mode_ff;
	logic [7:0] decim_ff;
	logic [15:0] nco_ff;
	logic w_main, w_ddc, w_link;

	assign w_main = wr && (area == pcr_pkg::SEL_MAIN);
	assign w_ddc = wr && (area == pcr_pkg::SEL_DDC);
	assign w_link = wr && (area == pcr_pkg::SEL_LINK);

	// Per-channel configuration; a software reset returns every field to zero.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dig_rst_ff <= 1'b0;
			ddc_en_ff <= 1'b0;
			decim_ff <= pcr_pkg::BYTE_RST;
			nco_ff <= pcr_pkg::WORD_RST;
			gain_ff <= 1'b0;
			scram_ff <= 1'b0;
			mode_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (sw_rst)
			begin
				dig_rst_ff <= 1'b0;
				ddc_en_ff <= 1'b0;
				decim_ff <= pcr_pkg::BYTE_RST;
				nco_ff <= pcr_pkg::WORD_RST;
				gain_ff <= 1'b0;
				scram_ff <= 1'b0;
				mode_ff <= 1'b0;
			end
			else
			begin
				if (w_main && off == pcr_pkg::OFF_DIG_RST)
					dig_rst_ff <= wdata[pcr_pkg::ENABLE_BIT];
				if (w_ddc && off == pcr_pkg::OFF_DDC_EN)
					ddc_en_ff <= wdata[pcr_pkg::ENABLE_BIT];
				if (w_ddc && off == pcr_pkg::OFF_DECIM)
					decim_ff <= wdata;
				if (w_ddc && off == pcr_pkg::OFF_NCO_LO)
					nco_ff[7:0] <= wdata;
				if (w_ddc && off == pcr_pkg::OFF_NCO_HI)
					nco_ff[15:8] <= wdata;
				if (w_ddc && off == pcr_pkg::OFF_GAIN)
					gain_ff <= wdata[pcr_pkg::ENABLE_BIT];
				if (w_link && off == pcr_pkg::OFF_SCRAM)
					scram_ff <= wdata[pcr_pkg::SCRAM_BIT];
				if (w_link && off == pcr_pkg::OFF_LINK_MODE)
					mode_ff <= wdata[pcr_pkg::ENABLE_BIT];
			end
		end
	end

	// Read-back of the addressed field; unmapped offsets read zero.
	always_comb
	begin
		rd_word = 8'h00;
		case (area)
			pcr_pkg::SEL_MAIN:
				if (off == pcr_pkg::OFF_DIG_RST)
					rd_word = {7'h00, dig_rst_ff};
			pcr_pkg::SEL_DDC:
				case (off)
					pcr_pkg::OFF_DDC_EN: rd_word = {7'h00, ddc_en_ff};
					pcr_pkg::OFF_DECIM: rd_word = decim_ff;
					pcr_pkg::OFF_NCO_LO: rd_word = nco_ff[7:0];
					pcr_pkg::OFF_NCO_HI: rd_word = nco_ff[15:8];
					pcr_pkg::OFF_GAIN: rd_word = {7'h00, gain_ff};
					default: rd_word = 8'h00;
				endcase
			pcr_pkg::SEL_LINK:
				case (off)
					pcr_pkg::OFF_SCRAM: rd_word = {scram_ff, 7'h00};
					pcr_pkg::OFF_LINK_MODE: rd_word = {7'h00, mode_ff};
					default: rd_word = 8'h00;
				endcase
			default: rd_word = 8'h00;
		endcase
	end

	assign dig_rst = dig_rst_ff;
	assign ddc_en = ddc_en_ff;
	assign decim = decim_ff;
	assign nco_word = nco_ff;
	assign gain6_en = gain_ff;
	assign scram_en = scram_ff;
	assign fmt_mode = mode_ff;

	// Checks on the channel fields.
	a_scram_write: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !sw_rst && w_link && off == pcr_pkg::OFF_SCRAM && wdata == 8'h80
		|=> scram_en)
		else $error("scrambler enable not taken");
	a_dig_reset: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !sw_rst && w_main && off == pcr_pkg::OFF_DIG_RST
		|=> dig_rst == $past(wdata[0]))
		else $error("digital reset bit does not follow write");
	a_decim_mode: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !sw_rst && w_ddc && off == pcr_pkg::OFF_DECIM && wdata == 8'h02
		|=> decim == 8'h02)
		else $error("decimation mode not stored");
	a_nco_bytes: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !sw_rst && w_ddc && off == pcr_pkg::OFF_NCO_HI
		|=> nco_word[15:8] == $past(wdata) && $stable(nco_word[7:0]))
		else $error("oscillator high byte wrong");
	a_gain_enable: assert property (@(posedge clk) disable iff (!arst_n)
		ce && !sw_rst && w_ddc && off == pcr_pkg::OFF_GAIN && wdata == 8'h01
		|=> gain6_en)
		else $error("gain stage not enabled");
endmodule // pcr_chan
`default_nettype wire

// ---- logic/pcr_top.sv ----
// What this block does
// - Software reset fires only when one write sets bits 7 and 0 together.
// - Both reset bits return to zero by themselves after the reset.
// - Three page bytes form a 24-bit selector choosing the paged destination.
// - 680000h main page first, 680100h main page second, 690000h link page.
// - 610000h function page first channel, 610100h function page second channel.
// - Selector bits 15:8 at 003h, 7:0 at 002h, 23:16 at 004h, reset zero.
// - On link page, 80h at 6006h or 7006h enables a channel's scrambler.
// - On main page, 01h at 6000h holds channel digital reset; 00h releases.
// - With 004h at 68h, byte 4003h 00h picks first, 01h second channel.
// - On link page, 01h at 6002h or 7002h sets channel format bit.
// - 01h at 5000h enables the first channel down-converter path.
// - 02h at 5001h or 5801h selects factor-eight complex decimation.
// - Oscillator word is low byte at x007h, high byte at x008h.
// - 01h at 5014h or 5814h enables the 6-dB gain stage.
`timescale 1ns/1ps
`default_nettype none
module pcr_top
#(
	parameter int ADDR_W = 16,
	parameter int NCH = 2
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic soft_reset,
	output logic [23:0] link_bank_page_selector,
	output logic page_main_a,
	output logic page_main_b,
	output logic page_func_a,
	output logic page_func_b,
	output logic page_link,
	output logic master_page,
	output logic global_pdn,
	output logic [NCH-1:0] dig_rst,
	output logic [NCH-1:0] ddc_en,
	output logic [NCH-1:0][7:0] decim,
	output logic [NCH-1:0][15:0] nco_word,
	output logic [NCH-1:0] gain6_en,
	output logic [NCH-1:0] scram_en,
	output logic [NCH-1:0] fmt_mode
);
	// The address decode is written for a 16-bit space and exactly two channels.
	if (ADDR_W != 16 || NCH != 2)
	begin : g_bad_param
		$error("pcr_top supports only ADDR_W 16 and NCH 2");
	end

	logic sw_rst_ff;
	logic [7:0] sel_lo_ff, sel_mid_ff, sel_hi_ff;
	logic [23:0] nxt_sel;
	pcr_pkg::pcr_page_e page_ff;
	logic master_ff, gpdn_ff;
	logic [7:0] rd_data_ff;
	logic rd_valid_ff;
	logic wr_ok, rd_ok;
	logic [1:0] ch_area [NCH];
	logic [11:0] ch_off [NCH];
	logic [7:0] ch_rd [NCH];
	logic [NCH-1:0] ch_hit;

	// True when the address names a page byte, directly or through its alias.
	function automatic logic is_page_byte(input logic [15:0] a, input logic [15:0] reg_addr);
		return (a[11:0] == reg_addr[11:0]) && (a[15:12] == 4'h0 || a[15:12] == pcr_pkg::ALIAS_AREA);
	endfunction

	// A write during the reset cycle is dropped so the reset leaves a clean state.
	assign wr_ok = ce && wr_en && !sw_rst_ff;
	assign rd_ok = ce && rd_en;

	// Software reset: lasts one cycle and both bits then read zero again.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			sw_rst_ff <= 1'b0;
		else if (ce)
			sw_rst_ff <= wr_ok && addr == pcr_pkg::ADDR_SOFT_RST
				&& wdata[pcr_pkg::SRST_HI_BIT] && wdata[pcr_pkg::SRST_LO_BIT];
	end

	// Next selector value; bytes change only when their own address is written or a software reset clears them.
	always_comb
	begin
		nxt_sel = {sel_hi_ff, sel_mid_ff, sel_lo_ff};
		if (sw_rst_ff)
			nxt_sel = pcr_pkg::SEL_RST;
		else if (wr_ok)
		begin
			if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_LO))
				nxt_sel[7:0] = wdata;
			if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_MID))
				nxt_sel[15:8] = wdata;
			if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_HI))
				nxt_sel[23:16] = wdata;
		end
	end

	// Selector bytes and the decoded page move together, so a paged access in the
	// cycle right after a page write already reaches the new page.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_lo_ff <= pcr_pkg::BYTE_RST;
			sel_mid_ff <= pcr_pkg::BYTE_RST;
			sel_hi_ff <= pcr_pkg::BYTE_RST;
			page_ff <= pcr_pkg::PAGE_NONE;
		end
		else if (ce)
		begin
			sel_lo_ff <= nxt_sel[7:0];
			sel_mid_ff <= nxt_sel[15:8];
			sel_hi_ff <= nxt_sel[23:16];
			page_ff <= pcr_pkg::pcr_decode(nxt_sel);
		end
	end

	// Master page select and global power-down; 20h only takes effect on the master page.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			master_ff <= 1'b0;
			gpdn_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (sw_rst_ff)
			begin
				master_ff <= 1'b0;
				gpdn_ff <= 1'b0;
			end
			else if (wr_ok)
			begin
				if (addr == pcr_pkg::ADDR_MASTER_SEL)
					master_ff <= wdata[pcr_pkg::MASTER_SEL_BIT];
				if (addr == pcr_pkg::ADDR_PDN && master_ff)
					gpdn_ff <= wdata[pcr_pkg::GPDN_BIT];
			end
		end
	end

	// Channel banks: the down-converter area is direct, main and link areas are paged.
	for (genvar c = 0; c < NCH; c++)
	begin : g_chan
		always_comb
		begin
			ch_area[c] = pcr_pkg::SEL_NONE;
			ch_off[c] = addr[11:0];
			if (addr[15:12] == pcr_pkg::AREA_DDC && addr[11] == 1'(c))
			begin
				ch_area[c] = pcr_pkg::SEL_DDC;
				ch_off[c] = {1'b0, addr[10:0]};
			end
			else if (page_ff == pcr_pkg::PAGE_LINK && addr[15:13] == pcr_pkg::AREA_LINK
				&& addr[12] == 1'(c))
				ch_area[c] = pcr_pkg::SEL_LINK;
			else if (addr[15:12] == pcr_pkg::AREA_MAIN
				&& page_ff == (c == 0 ? pcr_pkg::PAGE_MAIN_A : pcr_pkg::PAGE_MAIN_B))
				ch_area[c] = pcr_pkg::SEL_MAIN;
		end
		assign ch_hit[c] = ch_area[c] != pcr_pkg::SEL_NONE;

		pcr_chan u_chan
		(
			.clk(clk),
			.arst_n(arst_n),
			.ce(ce),
			.sw_rst(sw_rst_ff),
			.wr(wr_ok),
			.area(ch_area[c]),
			.off(ch_off[c]),
			.wdata(wdata),
			.rd_word(ch_rd[c]),
			.dig_rst(dig_rst[c]),
			.ddc_en(ddc_en[c]),
			.decim(decim[c]),
			.nco_word(nco_word[c]),
			.gain6_en(gain6_en[c]),
			.scram_en(scram_en[c]),
			.fmt_mode(fmt_mode[c])
		);
	end

	// Registered read port; unmapped addresses answer zero one cycle later.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
		end
		else if (ce)
		begin
			rd_valid_ff <= rd_ok;
			if (rd_ok)
			begin
				if (addr == pcr_pkg::ADDR_SOFT_RST)
					rd_data_ff <= {sw_rst_ff, 6'h00, sw_rst_ff};
				else if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_LO))
					rd_data_ff <= sel_lo_ff;
				else if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_MID))
					rd_data_ff <= sel_mid_ff;
				else if (is_page_byte(addr, pcr_pkg::ADDR_PAGE_HI))
					rd_data_ff <= sel_hi_ff;
				else if (addr == pcr_pkg::ADDR_MASTER_SEL)
					rd_data_ff <= {5'h00, master_ff, 2'h0};
				else if (addr == pcr_pkg::ADDR_PDN)
					rd_data_ff <= {7'h00, gpdn_ff};
				else if (ch_hit[0])
					rd_data_ff <= ch_rd[0];
				else if (ch_hit[1])
					rd_data_ff <= ch_rd[1];
				else
					rd_data_ff <= 8'h00;
			end
		end
	end

	assign rd_data = rd_data_ff;
	assign rd_valid = rd_valid_ff;
	assign soft_reset = sw_rst_ff;
	assign link_bank_page_selector = {sel_hi_ff, sel_mid_ff, sel_lo_ff};
	assign page_main_a = page_ff == pcr_pkg::PAGE_MAIN_A;
	assign page_main_b = page_ff == pcr_pkg::PAGE_MAIN_B;
	assign page_func_a = page_ff == pcr_pkg::PAGE_FUNC_A;
	assign page_func_b = page_ff == pcr_pkg::PAGE_FUNC_B;
	assign page_link = page_ff == pcr_pkg::PAGE_LINK;
	assign master_page = master_ff;
	assign global_pdn = gpdn_ff;

	// Checks on reset, selector and page decode.
	a_swrst_trigger: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h0000 && wdata == 8'h81 |=> soft_reset)
		else $error("soft reset not triggered");
	a_swrst_single_bit: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && addr == 16'h0000 && wdata[7] != wdata[0] |=> !soft_reset)
		else $error("soft reset from one bit");
	a_swrst_selfclr: assert property (@(posedge clk) disable iff (!arst_n)
		ce && soft_reset |=> !soft_reset && link_bank_page_selector == 24'h000000)
		else $error("soft reset did not clear");
	a_sel_mid_byte: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h4003
		|=> link_bank_page_selector[15:8] == $past(wdata))
		else $error("selector mid byte wrong");
	a_page_main_b: assert property (@(posedge clk) disable iff (!arst_n)
		link_bank_page_selector == 24'h680100 |-> page_main_b && !page_main_a)
		else $error("main page second channel not decoded");
	a_page_link: assert property (@(posedge clk) disable iff (!arst_n)
		link_bank_page_selector == 24'h690000 |-> page_link)
		else $error("link page not decoded");
	a_page_func: assert property (@(posedge clk) disable iff (!arst_n)
		page_func_a || page_func_b
		|-> link_bank_page_selector[23:16] == 8'h61 && link_bank_page_selector[7:0] == 8'h00)
		else $error("function page from wrong selector");
	a_sel_hold: assert property (@(posedge clk) disable iff (!arst_n)
		!(ce && (wr_en || soft_reset)) |=> $stable(link_bank_page_selector) && $stable(page_ff))
		else $error("selector changed without a write");
	a_read_latency: assert property (@(posedge clk) disable iff (!arst_n)
		ce && rd_en && addr == 16'h0000 && !soft_reset ##1 ce |-> rd_valid && rd_data == 8'h00)
		else $error("reset register read wrong");

	// Checks on the master page and the power-down that it guards.
	a_master_sel: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h0012 |=> master_page == $past(wdata[2]))
		else $error("master page bit not stored");
	a_pdn_guarded: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h0020 && !master_page
		|=> $stable(global_pdn))
		else $error("power-down taken off the master page");
	a_pdn_set: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h0020 && master_page
		|=> global_pdn == $past(wdata[0]))
		else $error("power-down bit not stored");

	// Checks on the low and high selector bytes and on the 680000h, 610000h, 610100h and unknown page codes.
	a_sel_lo_byte: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && (addr == 16'h0002 || addr == 16'h4002)
		|=> link_bank_page_selector[7:0] == $past(wdata))
		else $error("selector low byte wrong");
	a_sel_hi_byte: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && (addr == 16'h0004 || addr == 16'h4004)
		|=> link_bank_page_selector[23:16] == $past(wdata))
		else $error("selector high byte wrong");
	a_page_main_a: assert property (@(posedge clk) disable iff (!arst_n)
		link_bank_page_selector == 24'h680000 |-> page_main_a && !page_main_b && !page_link)
		else $error("main page first channel not decoded");
	a_page_func_a: assert property (@(posedge clk) disable iff (!arst_n)
		link_bank_page_selector == 24'h610000 |-> page_func_a && !page_func_b)
		else $error("function page first channel not decoded");
	a_page_func_b: assert property (@(posedge clk) disable iff (!arst_n)
		link_bank_page_selector == 24'h610100 |-> page_func_b && !page_func_a)
		else $error("function page second channel not decoded");
	a_page_unknown: assert property (@(posedge clk) disable iff (!arst_n)
		!(link_bank_page_selector inside {24'h680000, 24'h680100, 24'h610000, 24'h610100,
		24'h690000}) |-> !(page_main_a || page_main_b || page_func_a || page_func_b || page_link))
		else $error("page flag without a matching selector");

	// Paged and direct writes reach only the channel that the page or address names.
	a_dig_route_b: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && page_main_b && addr == 16'h6000
		|=> dig_rst[1] == $past(wdata[0]) && $stable(dig_rst[0]))
		else $error("digital reset reached the wrong channel");
	a_dig_route_a: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && page_main_a && addr == 16'h6000
		|=> dig_rst[0] == $past(wdata[0]) && $stable(dig_rst[1]))
		else $error("digital reset of first channel wrong");
	a_scram_route: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && page_link && addr == 16'h7006 && wdata == 8'h80
		|=> scram_en[1])
		else $error("second channel scrambler not enabled");
	a_mode_route: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && page_link && addr == 16'h6002 && wdata == 8'h01
		|=> fmt_mode[0])
		else $error("first channel format bit not set");
	a_paged_refused: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && !page_link && !page_main_a && !page_main_b
		&& addr[15:13] == 3'h3 |=> $stable(dig_rst) && $stable(scram_en) && $stable(fmt_mode))
		else $error("paged write taken with no page selected");
	a_ddc_direct: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h5000
		|=> ddc_en[0] == $past(wdata[0]) && $stable(ddc_en[1]))
		else $error("down-converter enable wrong");
	a_decim_b: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h5801 && wdata == 8'h02
		|=> decim[1] == 8'h02)
		else $error("second channel decimation not stored");
	a_nco_low_b: assert property (@(posedge clk) disable iff (!arst_n)
		ce && wr_en && !soft_reset && addr == 16'h5807
		|=> nco_word[1][7:0] == $past(wdata))
		else $error("second channel oscillator low byte wrong");

	// A soft reset leaves every field at zero; a page byte reads back its old value.
	a_swrst_clears: assert property (@(posedge clk) disable iff (!arst_n)
		ce && soft_reset |=> !master_page && !global_pdn && dig_rst == '0
		&& ddc_en == '0 && scram_en == '0 && fmt_mode == '0 && gain6_en == '0
		&& decim == '0 && nco_word == '0)
		else $error("soft reset left a field set");
	a_read_page_byte: assert property (@(posedge clk) disable iff (!arst_n)
		ce && rd_en && addr == 16'h0003
		|=> rd_valid && rd_data == $past(link_bank_page_selector[15:8]))
		else $error("selector mid byte read wrong");
endmodule // pcr_top
`default_nettype wire

// ---- testbench/pcr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcr_host
(
	input wire logic clk,
	output logic ce,
	output logic wr_en,
	output logic rd_en,
	output logic [15:0] addr,
	output logic [7:0] wdata
);
	// The bus starts enabled with both strobes low.
	initial
	begin
		ce = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
	end

	// Released lines show the inverse, so a stale value is never mistaken for data.
	task automatic idle();
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		ce = 1'b1;
		addr = ~addr;
		wdata = ~wdata;
	endtask

	// One write, held until its taking edge has passed.
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic e = 1'b1);
		@(posedge clk);
		#1;
		ce = e;
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		idle();
	endtask

	// One read; the answer is valid in the cycle after the taking edge.
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		addr = a;
		idle();
	endtask
endmodule // pcr_host
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce, wr_en, rd_en, rd_valid, soft_reset;
	logic [15:0] addr;
	logic [7:0] wdata, rd_data;
	logic [23:0] sel_o;
	logic pma, pmb, pfa, pfb, pl, mpg, gpd;
	logic [1:0] dig_rst, ddc_en, gain6_en, scram_en, fmt_mode;
	logic [1:0][7:0] decim;
	logic [1:0][15:0] nco_word;
	// Reference state of the register set.
	logic [23:0] sel;
	logic mp, pd;
	logic [1:0] dr, de, gn, sc, fm;
	logic [7:0] dc[2];
	logic [15:0] nc[2];
	logic [31:0] rs = 32'h3924;
	logic [7:0] b[3];
	logic [23:0] pv[6] = '{24'h680000, 24'h680100, 24'h610000, 24'h610100, 24'h690000, 24'h6A0000};
	logic [15:0] da[9] = '{16'h5000, 16'h5001, 16'h5007, 16'h5008, 16'h5014,
		16'h5801, 16'h5807, 16'h5808, 16'h5814};
	logic [7:0] dd[9] = '{8'h01, 8'h02, 8'h9A, 8'h99, 8'h01, 8'h02, 8'h9A, 8'h99, 8'h01};
	int num_errors = 0;
	int check_count = 0;

	always #5 clk = ~clk;

	pcr_host hst (.clk(clk), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));

	pcr_top uut (.clk(clk), .arst_n(arst_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .wdata(wdata), .rd_data(rd_data), .rd_valid(rd_valid),
		.soft_reset(soft_reset), .link_bank_page_selector(sel_o), .page_main_a(pma),
		.page_main_b(pmb), .page_func_a(pfa), .page_func_b(pfb), .page_link(pl),
		.master_page(mpg), .global_pdn(gpd), .dig_rst(dig_rst), .ddc_en(ddc_en),
		.decim(decim), .nco_word(nco_word), .gain6_en(gain6_en), .scram_en(scram_en),
		.fmt_mode(fmt_mode));

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Everything the soft reset and the pin reset clear.
	task automatic mclr();
		sel = 24'h0;
		{mp, pd, dr, de, gn, sc, fm} = '0;
		dc = '{8'h00, 8'h00};
		nc = '{16'h0000, 16'h0000};
	endtask

	// Reference effect of one write.
	task automatic mw(input logic [15:0] a, input logic [7:0] d);
		int c;
		c = a[15:12] == 4'h5 ? a[11] : a[12];
		if (a == 16'h0000 && d[7] && d[0]) mclr();
		else if (a == 16'h0002 || a == 16'h4002) sel[7:0] = d;
		else if (a == 16'h0003 || a == 16'h4003) sel[15:8] = d;
		else if (a == 16'h0004 || a == 16'h4004) sel[23:16] = d;
		else if (a == 16'h0012) mp = d[2];
		else if (a == 16'h0020 && mp) pd = d[0];
		else if (a[15:12] == 4'h5)
		begin
			case (a[10:0])
				11'h000: de[c] = d[0];
				11'h001: dc[c] = d;
				11'h007: nc[c][7:0] = d;
				11'h008: nc[c][15:8] = d;
				11'h014: gn[c] = d[0];
				default: ;
			endcase
		end
		else if (a[15:13] == 3'h3 && sel == 24'h690000 && a[11:0] == 12'h006) sc[c] = d[7];
		else if (a[15:13] == 3'h3 && sel == 24'h690000 && a[11:0] == 12'h002) fm[c] = d[0];
		else if (a == 16'h6000 && sel == 24'h680000) dr[0] = d[0];
		else if (a == 16'h6000 && sel == 24'h680100) dr[1] = d[0];
	endtask

	task automatic cmp_all();
		chk(sel_o, sel);
		chk({pma, pmb, pfa, pfb, pl}, {sel == 24'h680000, sel == 24'h680100,
			sel == 24'h610000, sel == 24'h610100, sel == 24'h690000});
		chk({mpg, gpd}, {mp, pd});
		for (int c = 0; c < 2; c++)
		begin
			chk({dig_rst[c], scram_en[c], fmt_mode[c]}, {dr[c], sc[c], fm[c]});
			chk({ddc_en[c], gain6_en[c], decim[c]}, {de[c], gn[c], dc[c]});
			chk(nco_word[c], nc[c]);
		end
	endtask

	task automatic w(input logic [15:0] a, input logic [7:0] d);
		hst.wr(a, d);
		mw(a, d);
		cmp_all();
	endtask

	task automatic r(input logic [15:0] a, input logic [7:0] e);
		hst.rd(a);
		chk({rd_valid, rd_data}, {1'b1, e});
		@(posedge clk);
		#1;
		chk(rd_valid, 1'b0);
	endtask

	task automatic tend(input int n);
		$display("test %0d done", n);
	endtask

	// Cuts a hang short well past the expected run length.
	initial
	begin
		#100000;
		num_errors++;
		$display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
		stop_test();
	end

	initial
	begin
		mclr();
		repeat (20) @(posedge clk);
		#1;
		arst_n = 1'b1;
		cmp_all();
		r(16'h0000, 8'h00);
		r(16'h0002, 8'h00);
		r(16'h0100, 8'h00);
		tend(1);
		for (int i = 0; i < 4; i++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				rs = lfsr(rs);
				b[k] = rs[7:0];
				w((i[0] ? 16'h4002 : 16'h0002) + k[15:0], b[k]);
			end
			r(16'h0003, b[1]);
			r(16'h4004, b[2]);
		end
		tend(2);
		foreach (pv[i])
		begin
			w(16'h4004, pv[i][23:16]);
			w(16'h4003, pv[i][15:8]);
			w(16'h4002, pv[i][7:0]);
		end
		w(16'h6002, 8'h01);
		tend(3);
		w(16'h0020, 8'h01);
		w(16'h0012, 8'h04);
		w(16'h0020, 8'h01);
		tend(4);
		w(16'h4004, 8'h69);
		w(16'h4003, 8'h00);
		w(16'h6006, 8'h80);
		w(16'h7006, 8'h80);
		r(16'h6006, 8'h80);
		w(16'h6002, 8'h01);
		w(16'h7002, 8'h01);
		tend(5);
		w(16'h4004, 8'h68);
		w(16'h6006, 8'h00);
		r(16'h6006, 8'h00);
		w(16'h6000, 8'h01);
		w(16'h6000, 8'h00);
		w(16'h4003, 8'h01);
		w(16'h6000, 8'h01);
		tend(6);
		foreach (da[i])
			w(da[i], dd[i]);
		hst.wr(16'h5001, 8'h55, 1'b0);
		cmp_all();
		tend(7);
		w(16'h0000, 8'h80);
		w(16'h0000, 8'h01);
		chk(soft_reset, 1'b0);
		hst.wr(16'h0000, 8'h81);
		chk(soft_reset, 1'b1);
		@(posedge clk);
		#1;
		chk(soft_reset, 1'b0);
		mclr();
		cmp_all();
		r(16'h0000, 8'h00);
		tend(8);
		// A pin reset in mid-run must clear a selector that was just written.
		w(16'h4004, 8'h69);
		arst_n = 1'b0;
		@(posedge clk);
		#1;
		arst_n = 1'b1;
		mclr();
		cmp_all();
		r(16'h4004, 8'h00);
		tend(9);
		stop_test();
	end
endmodule // tb
`default_nettype wire
